// File: rtl/spcs_top.sv
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "spcs_regs.svh"

// Function
// - With both wide bits clear only partitions A and B of sixteen channels select channels.
// - After reset the wide bits are clear so the 32-channel scheme is in force.
// - With both wide bits set up to 128 channels per frame are selectable each way.
// - Six receive and six transmit enable registers gate partitions C to H.
// - Partition p covers channels 16p to 16p+15, so H holds channels 112 to 127.
// - Bit n of a receive enable register admits channel n of its partition.
// - Bit n of a transmit enable register drives channel n of its partition.
// - All enable bits are read-write and reset to zero.
// - Clock stop mode handles a single-phase frame of exactly one word.
// - Word length is 8, 12, 16, 20, 24 or 32 bits.
// - In SPI mode transmitter and receiver share one master or slave role.
// - The link logic is static and keeps state at any low bit clock rate.
// - Serial transfers go on while the processor core is halted.
// - The receive wide bit sits in control register one, transmit in two.
// - In multichannel mode each channel is enabled per direction on its own.
module spcs_top
    import spcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic link_clk_i,
    input wire logic fs_i,
    input wire logic dr_i,
    output logic dx_o,
    output logic dx_oe_o,
    output logic spi_master_o
);
    localparam int CFG_W = 128 + 128 + 32 + 5;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic en_hit(input logic [7:0] adr,
                                    input logic [7:0] base);
        return adr[7:5] == base[7:5];
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
            r[7:0] = d[7:0];
        if (sel[1])
            r[15:8] = d[15:8];
        return r;
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic ack_r;
    logic [31:0] dat_r;
    logic [5:0] ctrl_r;
    logic [1:0] mc_one_r;
    logic [1:0] mc_two_r;
    logic [31:0] txdata_r;
    logic [15:0] rx_en_r [`SPCS_PARTS];
    logic [15:0] tx_en_r [`SPCS_PARTS];
    logic rx_full_r;
    logic ovr_r;
    logic [31:0] rxword_r;
    logic [6:0] rxch_r;
    logic cfg_dirty_r;

    logic req;
    logic wr_go;
    logic rd_go;
    logic [2:0] part;
    logic [127:0] rx_eff;
    logic [127:0] tx_eff;
    logic [CFG_W-1:0] cfg_cur;
    logic cfg_busy;
    logic [CFG_W-1:0] cfg_l;
    logic [38:0] rx_l;
    logic [38:0] rx_c;
    logic rx_pulse;

    assign req = wb_cyc_i && wb_stb_i;
    // Effects land on the edge at which the master sees ack
    assign wr_go = req && ack_r && wb_we_i;
    assign rd_go = req && ack_r && !wb_we_i;
    assign part = wb_adr_i[4:2];

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= req && !ack_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_r <= 32'h0000_0000;
        else if (req && !ack_r)
        begin
            dat_r <= 32'h0000_0000;
            if (en_hit(wb_adr_i, `SPCS_ADR_RX_EN))
                dat_r[15:0] <= rx_en_r[part];
            else if (en_hit(wb_adr_i, `SPCS_ADR_TX_EN))
                dat_r[15:0] <= tx_en_r[part];
            else
            begin
                unique case (wb_adr_i)
                    `SPCS_ADR_CTRL: dat_r[5:0] <= ctrl_r;
                    `SPCS_ADR_STAT:
                    begin
                        dat_r[`SPCS_STAT_RXFULL] <= rx_full_r;
                        dat_r[`SPCS_STAT_OVR] <= ovr_r;
                        dat_r[`SPCS_STAT_CFGBUSY] <= cfg_dirty_r || cfg_busy;
                        dat_r[`SPCS_STAT_CH_MSB:`SPCS_STAT_CH_LSB] <= rxch_r;
                    end
                    `SPCS_ADR_TXDATA: dat_r <= txdata_r;
                    `SPCS_ADR_RXDATA: dat_r <= rxword_r;
                    `SPCS_ADR_MC_ONE: dat_r[1:0] <= mc_one_r;
                    `SPCS_ADR_MC_TWO: dat_r[1:0] <= mc_two_r;
                    default: dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= `SPCS_CTRL_RESET;
            mc_one_r <= `SPCS_MC_RESET;
            mc_two_r <= `SPCS_MC_RESET;
            txdata_r <= `SPCS_TXDATA_RESET;
        end
        else if (wr_go)
        begin
            if (wb_adr_i == `SPCS_ADR_CTRL && wb_sel_i[0])
                ctrl_r <= wb_dat_i[5:0];
            if (wb_adr_i == `SPCS_ADR_MC_ONE && wb_sel_i[0])
                mc_one_r <= wb_dat_i[1:0];
            if (wb_adr_i == `SPCS_ADR_MC_TWO && wb_sel_i[0])
                mc_two_r <= wb_dat_i[1:0];
            if (wb_adr_i == `SPCS_ADR_TXDATA)
            begin
                for (int b = 0; b < 4; b++)
                    if (wb_sel_i[b])
                        txdata_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int p = 0; p < `SPCS_PARTS; p++)
            begin
                rx_en_r[p] <= `SPCS_EN_RESET;
                tx_en_r[p] <= `SPCS_EN_RESET;
            end
        end
        else if (wr_go)
        begin
            if (en_hit(wb_adr_i, `SPCS_ADR_RX_EN))
                rx_en_r[part] <= merge16(rx_en_r[part], wb_dat_i,
                                         wb_sel_i);
            if (en_hit(wb_adr_i, `SPCS_ADR_TX_EN))
                tx_en_r[part] <= merge16(tx_en_r[part], wb_dat_i,
                                         wb_sel_i);
        end
    end

    assign spi_master_o = ctrl_r[`SPCS_CTRL_MASTER];

    // ------------------------------------------------------------
    // Effective channel map, one bit per channel
    // ------------------------------------------------------------
    // Without multichannel selection every channel passes
    for (genvar p = 0; p < `SPCS_PARTS; p++)
    begin : g_eff
        localparam logic NARROW = p < `SPCS_NARROW_PARTS;
        assign rx_eff[p*16 +: 16] = !mc_one_r[`SPCS_MC_SEL] ? 16'hffff :
            (NARROW || mc_one_r[`SPCS_MC_WIDE]) ? rx_en_r[p] :
            16'h0000;
        assign tx_eff[p*16 +: 16] = !mc_two_r[`SPCS_MC_SEL] ? 16'hffff :
            (NARROW || mc_two_r[`SPCS_MC_WIDE]) ? tx_en_r[p] :
            16'h0000;
    end

    assign cfg_cur = {ctrl_r[`SPCS_CTRL_ENABLE],
                      ctrl_r[`SPCS_CTRL_CSTOP],
                      ctrl_r[`SPCS_CTRL_LEN_MSB:`SPCS_CTRL_LEN_LSB],
                      txdata_r, tx_eff, rx_eff};

    // A write during the load keeps the flag up for another pass
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_dirty_r <= 1'b0;
        else if (wr_go)
            cfg_dirty_r <= 1'b1;
        else if (!cfg_busy)
            cfg_dirty_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Received word status
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rxword_r <= 32'h0000_0000;
            rxch_r <= 7'h00;
        end
        else if (rx_pulse)
        begin
            rxword_r <= rx_c[31:0];
            rxch_r <= rx_c[38:32];
        end
    end

    // Arrival beats a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rx_full_r <= 1'b0;
        else if (rx_pulse)
            rx_full_r <= 1'b1;
        else if (rd_go && wb_adr_i == `SPCS_ADR_RXDATA)
            rx_full_r <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ovr_r <= 1'b0;
        else if (rx_pulse && rx_full_r)
            ovr_r <= 1'b1;
        else if (wr_go && wb_adr_i == `SPCS_ADR_STAT &&
                 wb_sel_i[0] && wb_dat_i[`SPCS_STAT_OVR])
            ovr_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Crossings
    // ------------------------------------------------------------
    logic lrst;
    logic rx_push;

    spcs_sync u_rst_sync
    (
        .clk_i(link_clk_i),
        .rst_i(1'b0),
        .d_i(rst_i),
        .q_o(lrst)
    );

    spcs_xfer #(.W(CFG_W)) u_cfg_xfer
    (
        .src_clk_i(clk_i),
        .src_rst_i(rst_i),
        .src_valid_i(cfg_dirty_r),
        .src_data_i(cfg_cur),
        .src_busy_o(cfg_busy),
        .dst_clk_i(link_clk_i),
        .dst_rst_i(lrst),
        .dst_data_o(cfg_l),
        .dst_pulse_o()
    );

    spcs_xfer #(.W(39)) u_rx_xfer
    (
        .src_clk_i(link_clk_i),
        .src_rst_i(lrst),
        .src_valid_i(rx_push),
        .src_data_i(rx_l),
        .src_busy_o(),
        .dst_clk_i(clk_i),
        .dst_rst_i(rst_i),
        .dst_data_o(rx_c),
        .dst_pulse_o(rx_pulse)
    );

    // ------------------------------------------------------------
    // Link engine, on the bit clock only
    // ------------------------------------------------------------
    // No tie to the core's run state, so halts leave it running
    spcs_lstate_t state_r;
    logic [4:0] bit_r;
    logic [6:0] ch_r;
    logic [31:0] rsh_r;
    logic [31:0] tsh_r;
    logic dx_r;
    logic oe_r;
    logic [4:0] last;
    logic l_en;
    logic l_cstop;
    logic [31:0] l_tx;
    logic [127:0] l_rx_eff;
    logic [127:0] l_tx_eff;
    logic [31:0] tx_al;
    logic word_done;
    logic [6:0] ch_next;

    assign l_rx_eff = cfg_l[127:0];
    assign l_tx_eff = cfg_l[255:128];
    assign l_tx = cfg_l[287:256];
    assign last = spcs_last_bit(cfg_l[290:288]);
    assign l_cstop = cfg_l[291];
    assign l_en = cfg_l[292];
    assign tx_al = l_tx << (5'h1f - last);
    assign word_done = state_r == SPCS_RUN && !fs_i && bit_r == last;
    assign ch_next = ch_r + 7'h01;
    assign rx_push = word_done && l_rx_eff[ch_r];
    assign rx_l = {ch_r, rsh_r[30:0], dr_i};

    // Pure edge-driven state: any low bit clock rate works
    always_ff @(posedge link_clk_i)
    begin
        if (lrst)
        begin
            state_r <= SPCS_IDLE;
            bit_r <= 5'h00;
            ch_r <= 7'h00;
            rsh_r <= 32'h0000_0000;
            tsh_r <= 32'h0000_0000;
            dx_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else if (fs_i && l_en)
        begin
            state_r <= SPCS_RUN;
            bit_r <= 5'h01;
            ch_r <= 7'h00;
            rsh_r <= {31'h0000_0000, dr_i};
            dx_r <= tx_al[31];
            tsh_r <= {tx_al[30:0], 1'b0};
            oe_r <= l_tx_eff[0];
        end
        else
        begin
            unique case (state_r)
                SPCS_IDLE:
                begin
                    oe_r <= 1'b0;
                end
                SPCS_RUN:
                begin
                    if (word_done)
                    begin
                        rsh_r <= 32'h0000_0000;
                        bit_r <= 5'h00;
                        // Last bit still goes out; next word loads behind it
                        dx_r <= tsh_r[31];
                        tsh_r <= tx_al;
                        // One word per frame in clock stop mode
                        if (l_cstop || ch_r == `SPCS_LAST_CH)
                            state_r <= SPCS_IDLE;
                        else
                            ch_r <= ch_next;
                    end
                    else
                    begin
                        bit_r <= bit_r + 5'h01;
                        rsh_r <= {rsh_r[30:0], dr_i};
                        dx_r <= tsh_r[31];
                        tsh_r <= {tsh_r[30:0], 1'b0};
                        if (bit_r == 5'h00)
                            oe_r <= l_tx_eff[ch_r];
                    end
                end
            endcase
        end
    end

    assign dx_o = dx_r;
    assign dx_oe_o = oe_r;
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_req_new;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req_new |=> s_ack_once)
        else $error("ack not one cycle after request");

    a_reset_clears_en: assert property (@(posedge clk_i)
        rst_i |=> rx_en_r[7] == 16'h0000 && tx_en_r[2] == 16'h0000)
        else $error("enable register not zero after reset");

    a_reset_narrow: assert property (@(posedge clk_i)
        rst_i |=> !mc_one_r[`SPCS_MC_WIDE] && !mc_two_r[`SPCS_MC_WIDE])
        else $error("wide mode set after reset");

    a_narrow_ignores_ch: assert property (@(posedge clk_i)
        disable iff (rst_i)
        mc_one_r[`SPCS_MC_SEL] && !mc_one_r[`SPCS_MC_WIDE]
        |-> rx_eff[127:32] == 96'h0)
        else $error("upper receive partitions active in narrow mode");

    a_wide_part_h: assert property (@(posedge clk_i)
        disable iff (rst_i)
        mc_two_r == 2'b11 |-> tx_eff[127:112] == tx_en_r[7])
        else $error("partition H not mapped to channels 112 to 127");

    a_en_write_lands: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_go && en_hit(wb_adr_i, `SPCS_ADR_RX_EN) && wb_sel_i[1:0] == 2'b11
        |=> rx_en_r[$past(part)] == $past(wb_dat_i[15:0]))
        else $error("receive enable write lost");

    a_rx_full_set: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_pulse |=> rx_full_r && rxword_r == $past(rx_c[31:0]))
        else $error("received word not flagged");

    a_word_length: assert property (@(posedge link_clk_i)
        disable iff (lrst)
        state_r == SPCS_RUN |-> bit_r <= last)
        else $error("bit count ran past word length");

    a_spi_one_word: assert property (@(posedge link_clk_i)
        disable iff (lrst)
        word_done && l_cstop && !fs_i |=> !fs_i |-> state_r == SPCS_IDLE)
        else $error("clock stop frame held more than one word");

    a_tx_gate: assert property (@(posedge link_clk_i)
        disable iff (lrst)
        state_r == SPCS_RUN && !l_tx_eff[ch_r] && !$changed(ch_r)
        |-> !dx_oe_o)
        else $error("disabled channel driven");
endmodule

// File: rtl/spcs_regs.svh
`ifndef SPCS_REGS_SVH
`define SPCS_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPCS_ADR_CTRL 8'h00
`define SPCS_ADR_STAT 8'h04
`define SPCS_ADR_TXDATA 8'h08
`define SPCS_ADR_RXDATA 8'h0c
`define SPCS_ADR_MC_ONE 8'h10
`define SPCS_ADR_MC_TWO 8'h14
`define SPCS_ADR_RX_EN 8'h40
`define SPCS_ADR_TX_EN 8'h60

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPCS_CTRL_LEN_LSB 0
`define SPCS_CTRL_LEN_MSB 2
`define SPCS_CTRL_CSTOP 3
`define SPCS_CTRL_MASTER 4
`define SPCS_CTRL_ENABLE 5
`define SPCS_MC_SEL 0
`define SPCS_MC_WIDE 1
`define SPCS_STAT_RXFULL 0
`define SPCS_STAT_OVR 1
`define SPCS_STAT_CFGBUSY 2
`define SPCS_STAT_CH_LSB 8
`define SPCS_STAT_CH_MSB 14

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define SPCS_CTRL_RESET 6'h00
`define SPCS_MC_RESET 2'h0
`define SPCS_EN_RESET 16'h0000
`define SPCS_TXDATA_RESET 32'h0000_0000
`define SPCS_PARTS 8
`define SPCS_NARROW_PARTS 2
`define SPCS_LAST_CH 7'h7f

`endif

// File: rtl/spcs_pkg.sv
package spcs_pkg;

    typedef enum logic [2:0]
    {
        SPCS_WL8 = 3'b000,
        SPCS_WL12 = 3'b001,
        SPCS_WL16 = 3'b010,
        SPCS_WL20 = 3'b011,
        SPCS_WL24 = 3'b100,
        SPCS_WL32 = 3'b101
    } spcs_wl_t;

    typedef enum logic
    {
        SPCS_IDLE = 1'b0,
        SPCS_RUN = 1'b1
    } spcs_lstate_t;

    // Index of the last bit of a word for a length code
    function automatic logic [4:0] spcs_last_bit(input logic [2:0] code);
        logic [4:0] r;
        r = 5'h1f;
        unique case (code)
            SPCS_WL8: r = 5'h07;
            SPCS_WL12: r = 5'h0b;
            SPCS_WL16: r = 5'h0f;
            SPCS_WL20: r = 5'h13;
            SPCS_WL24: r = 5'h17;
            SPCS_WL32: r = 5'h1f;
            default: r = 5'h1f;
        endcase
        return r;
    endfunction

endpackage

// File: rtl/spcs_sync.sv
`timescale 1ns/1ps

// Three-stage synchroniser; output moves once stages two and three agree
module spcs_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else
        begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            q_r <= 1'b0;
        else if (s2_r == s3_r)
            q_r <= s3_r;
    end

    assign q_o = q_r;
endmodule

// File: rtl/spcs_xfer.sv
`timescale 1ns/1ps

// Word crossing by toggle request and toggle acknowledge
module spcs_xfer
#(
    parameter int W = 8
)
(
    input wire logic src_clk_i,
    input wire logic src_rst_i,
    input wire logic src_valid_i,
    input wire logic [W-1:0] src_data_i,
    output logic src_busy_o,
    input wire logic dst_clk_i,
    input wire logic dst_rst_i,
    output logic [W-1:0] dst_data_o,
    output logic dst_pulse_o
);
    logic [W-1:0] held_r;
    logic req_r;
    logic ack_s;
    logic req_s;
    logic seen_r;
    logic [W-1:0] dst_r;
    logic pulse_r;

    assign src_busy_o = req_r != ack_s;

    // Held word stays still until the far side has taken it
    always_ff @(posedge src_clk_i)
    begin
        if (src_rst_i)
        begin
            held_r <= '0;
            req_r <= 1'b0;
        end
        else if (src_valid_i && !src_busy_o)
        begin
            held_r <= src_data_i;
            req_r <= ~req_r;
        end
    end

    spcs_sync u_req_sync
    (
        .clk_i(dst_clk_i),
        .rst_i(dst_rst_i),
        .d_i(req_r),
        .q_o(req_s)
    );

    spcs_sync u_ack_sync
    (
        .clk_i(src_clk_i),
        .rst_i(src_rst_i),
        .d_i(seen_r),
        .q_o(ack_s)
    );

    always_ff @(posedge dst_clk_i)
    begin
        if (dst_rst_i)
        begin
            seen_r <= 1'b0;
            dst_r <= '0;
            pulse_r <= 1'b0;
        end
        else
        begin
            pulse_r <= req_s != seen_r;
            if (req_s != seen_r)
            begin
                seen_r <= req_s;
                dst_r <= held_r;
            end
        end
    end

    assign dst_data_o = dst_r;
    assign dst_pulse_o = pulse_r;
endmodule

// File: testbench/spcs_far.sv
`timescale 1ns/1ps

// ----------------------------------------
// Far-end TDM framer, 8-bit words
// ----------------------------------------
module spcs_far
(
    output logic link_clk_o,
    output logic fs_o,
    output logic dr_o,
    input wire logic dx_i,
    input wire logic dx_oe_i
);
    logic [31:0] tx_w;
    logic [7:0] w;
    int oe_bits;

    initial
    begin
        link_clk_o = 1'b0;
        fs_o = 1'b0;
        dr_o = 1'b0;
        tx_w = 32'h0;
        oe_bits = 0;
    end

    // 32 ns bit clock keeps the link rate far below the limit
    task automatic ticks(input int n);
        #3;
        repeat (n)
        begin
            #16 link_clk_o = 1'b1;
            #16 link_clk_o = 1'b0;
        end
    endtask

    // Word of channel ch is ch ^ 5a; dx sampled at the falling edge
    task automatic frame(input int nch);
        #3;
        for (int ch = 0; ch < nch; ch++)
        begin
            w = 8'(ch) ^ 8'h5a;
            for (int b = 7; b >= 0; b--)
            begin
                fs_o = (ch == 0 && b == 7);
                dr_o = w[b];
                #16 link_clk_o = 1'b1;
                #16 link_clk_o = 1'b0;
                if (dx_oe_i === 1'b1)
                begin
                    tx_w = {tx_w[30:0], dx_i};
                    oe_bits++;
                end
            end
        end
        fs_o = 1'b0;
        // Released line shows the inverse, not a stale bit
        dr_o = ~dr_o;
        ticks(8);
    endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`include "spcs_regs.svh"

module tb_top;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic link_clk, fs, dr, dx, dx_oe, spi_master;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, sel;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int errors, checked, cycles;

    spcs_top dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .link_clk_i(link_clk), .fs_i(fs),
        .dr_i(dr), .dx_o(dx), .dx_oe_o(dx_oe), .spi_master_o(spi_master)
    );

    spcs_far far
    (
        .link_clk_o(link_clk), .fs_o(fs), .dr_o(dr),
        .dx_i(dx), .dx_oe_i(dx_oe)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Link clock only runs inside far tasks, so config crosses while polled
    task automatic cfg();
        do
        begin
            far.ticks(4);
            wb(1'b0, `SPCS_ADR_STAT, 32'h0);
        end while (rd[`SPCS_STAT_CFGBUSY] !== 1'b0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0] a;
        wb(1'b0, `SPCS_ADR_MC_ONE, 32'h0);
        chk(rd, 32'h0, "rx mode after reset");
        wb(1'b0, `SPCS_ADR_MC_TWO, 32'h0);
        chk(rd, 32'h0, "tx mode after reset");
        for (int i = 0; i < 16; i++)
        begin
            a = (i < 8) ? 8'(`SPCS_ADR_RX_EN + 4 * i) :
                8'(`SPCS_ADR_TX_EN + 4 * (i - 8));
            wb(1'b0, a, 32'h0);
            chk(rd, 32'h0, "enable reset value");
            wb(1'b1, a, 32'h0000a5c3 ^ 32'(i));
            wb(1'b0, a, 32'h0);
            chk(rd, 32'h0000a5c3 ^ 32'(i), "enable readback");
            wb(1'b1, a, 32'h0);
        end
        sel = 4'h2;
        wb(1'b1, `SPCS_ADR_TX_EN, 32'h0000ffff);
        sel = 4'hf;
        wb(1'b0, `SPCS_ADR_TX_EN, 32'h0);
        chk(rd, 32'h0000ff00, "byte lane write");
        wb(1'b1, `SPCS_ADR_TX_EN, 32'h0);
        wb(1'b0, 8'h80, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        wb(1'b1, `SPCS_ADR_CTRL, 32'h30);
        @(posedge clk_i);
        chk(32'(spi_master), 32'h1, "shared spi role");
        $display("test regs done");
    endtask

    task automatic t_rx();
        wb(1'b1, `SPCS_ADR_CTRL, 32'h20);
        wb(1'b1, `SPCS_ADR_MC_ONE, 32'h1);
        wb(1'b1, `SPCS_ADR_RX_EN, 32'h0002);
        cfg();
        far.frame(4);
        wb(1'b0, `SPCS_ADR_STAT, 32'h0);
        chk(32'(rd[14:8]), 32'h1, "rx channel");
        wb(1'b0, `SPCS_ADR_RXDATA, 32'h0);
        chk(rd, 32'h5b, "rx word");
        $display("test rx done");
    endtask

    task automatic t_wide();
        wb(1'b1, `SPCS_ADR_RX_EN, 32'h0);
        wb(1'b1, 8'(`SPCS_ADR_RX_EN + 28), 32'h8000);
        cfg();
        far.frame(128);
        wb(1'b0, `SPCS_ADR_STAT, 32'h0);
        chk(32'(rd[0]), 32'h0, "narrow mode ignores H");
        wb(1'b1, `SPCS_ADR_MC_ONE, 32'h3);
        cfg();
        far.frame(128);
        wb(1'b0, `SPCS_ADR_STAT, 32'h0);
        chk(32'(rd[14:8]), 32'h7f, "last channel");
        wb(1'b0, `SPCS_ADR_RXDATA, 32'h0);
        chk(rd, 32'h25, "channel 127 word");
        $display("test wide done");
    endtask

    task automatic t_tx();
        wb(1'b1, `SPCS_ADR_MC_TWO, 32'h1);
        wb(1'b1, `SPCS_ADR_TX_EN, 32'h0001);
        wb(1'b1, `SPCS_ADR_TXDATA, 32'h000000a5);
        cfg();
        far.oe_bits = 0;
        far.frame(4);
        chk(32'(far.oe_bits), 32'h8, "tx driven bits");
        chk(far.tx_w & 32'hff, 32'ha5, "tx word");
        wb(1'b1, `SPCS_ADR_TX_EN, 32'h0003);
        wb(1'b1, `SPCS_ADR_CTRL, 32'h28);
        cfg();
        far.oe_bits = 0;
        far.frame(4);
        chk(32'(far.oe_bits), 32'h8, "clock stop one word");
        $display("test tx done");
    endtask

    initial
    begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        sel = 4'hf;
        wb_dat_i = 32'h0;
        fork
            repeat (16) @(posedge clk_i);
            far.ticks(8);
        join
        @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_rx();
        t_wide();
        t_tx();
        test_done();
    end
endmodule
